//--- design/rmw_pkg.sv
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
package rmw_pkg;
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] STAT_ADDR = 12'h004;
  localparam logic [11:0] WDOG_ADDR = 12'h008;
  localparam int CTRL_UNLOCK_BIT = 7;
  localparam int CTRL_PCFG_BIT = 6;
  localparam int CTRL_BADADDR_BIT = 5;
  localparam int CTRL_WDOG_BIT = 4;
  localparam int STAT_SLEEP_BIT = 7;
  localparam logic [7:0] WDOG_KEY1 = 8'h0a;
  localparam logic [7:0] WDOG_KEY2 = 8'h03;
  localparam logic [3:0] WDOG_TRIP = 4'h8;
  localparam int POR_MS = 10;
  localparam int CLK_MHZ = 250;
  localparam int POR_CYCLES = POR_MS * 1000 * CLK_MHZ;
  localparam logic [7:0] CTRL_RST = 8'h00;
  typedef enum logic [1:0] {RMW_POR, RMW_RUN, RMW_SLEEP} rmw_state_e;
  typedef struct packed {
    logic pwr;
    logic sys;
    logic pcfg;
    logic dormant;
  } rmw_rst_s;
endpackage : rmw_pkg

//--- design/rmw_top.sv
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module rmw_top #(
  parameter int POR_COUNT = rmw_pkg::POR_CYCLES,
  parameter bit PIN_IS_COLD = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic regulator_ready,
  input wire logic reset_pin,
  input wire logic port_combo_req,
  input wire logic bad_address_req,
  input wire logic wdog_tick,
  input wire logic rc_osc_enable,
  input wire logic ext_clk_in_use,
  output rmw_pkg::rmw_rst_s rst_q
);
  // ---------------------------------------------------------------------------
  // Input synchronisers.
  // ---------------------------------------------------------------------------
  logic [5:0] s1_q, s2_q;
  logic pin_s, combo_s, badaddr_s, tick_s, rc_s, ext_s, tick_d1_q;
  // Only the second stage is read; first stage feeds nothing else.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 6'h00;
      s2_q <= 6'h00;
    end else begin
      s1_q <= {reset_pin, port_combo_req, bad_address_req, wdog_tick, rc_osc_enable,
               ext_clk_in_use};
      s2_q <= s1_q;
    end
  end
  assign {pin_s, combo_s, badaddr_s, tick_s, rc_s, ext_s} = s2_q;

  // ---------------------------------------------------------------------------
  // Power-up sequencing.
  // ---------------------------------------------------------------------------
  rmw_pkg::rmw_state_e state_q;
  logic [31:0] por_cnt_q;
  logic [1:0] rg_q;
  logic pwr_rst, sleep_go, pin_cold, warm_src;
  // The regulator flag is synchronised before use.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rg_q <= 2'b00;
    end else begin
      rg_q <= {rg_q[0], regulator_ready};
    end
  end
  // presetn models the supply edge; the count runs only once the regulator is up.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_cnt_q <= 32'h0;
    end else if (state_q == rmw_pkg::RMW_POR && rg_q[1]) begin
      por_cnt_q <= por_cnt_q + 32'h1;
    end
  end
  assign pin_cold = PIN_IS_COLD && pin_s;
  // A pin on later revisions is a cold source; it asserts power-up reset while held but does not rerun the count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= rmw_pkg::RMW_POR;
    end else begin
      case (state_q)
        rmw_pkg::RMW_POR: begin
          if (rg_q[1] && por_cnt_q >= POR_COUNT - 1) state_q <= rmw_pkg::RMW_RUN;
        end
        rmw_pkg::RMW_RUN: begin
          if (sleep_go) state_q <= rmw_pkg::RMW_SLEEP;
        end
        rmw_pkg::RMW_SLEEP: begin
          if (pin_s || combo_s) state_q <= rmw_pkg::RMW_RUN;
        end
        default: state_q <= rmw_pkg::RMW_POR;
      endcase
    end
  end
  assign pwr_rst = (state_q == rmw_pkg::RMW_POR) || pin_cold;

  // ---------------------------------------------------------------------------
  // APB slave.
  // ---------------------------------------------------------------------------
  logic acc, wr, hit_ctrl, hit_stat, hit_wdog, unmapped;
  logic [7:0] ctrl_q, flags_q;
  logic [3:0] wd_cnt_q;
  logic key_armed_q;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign hit_ctrl = paddr == rmw_pkg::CTRL_ADDR;
  assign hit_stat = paddr == rmw_pkg::STAT_ADDR;
  assign hit_wdog = paddr == rmw_pkg::WDOG_ADDR;
  assign unmapped = !(hit_ctrl || hit_stat || hit_wdog);
  // Zero wait states; unmapped addresses answer with an error and zeros.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && unmapped;
      if (psel && !penable && !pwrite) begin
        prdata <= hit_ctrl ? {24'h0, ctrl_q} :
                  hit_stat ? {24'h0, flags_q} :
                  hit_wdog ? {28'h0, wd_cnt_q} : 32'h0;
      end
    end
  end
  logic wr_done;
  assign wr_done = wr && pready;

  // ---------------------------------------------------------------------------
  // Control register.
  // ---------------------------------------------------------------------------
  // Watchdog enable can be set but only power-up clears it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= rmw_pkg::CTRL_RST;
    end else if (pwr_rst) begin
      ctrl_q <= rmw_pkg::CTRL_RST;
    end else if (wr_done && hit_ctrl) begin
      ctrl_q[7:5] <= pwdata[7:5];
      ctrl_q[rmw_pkg::CTRL_WDOG_BIT] <= ctrl_q[rmw_pkg::CTRL_WDOG_BIT] |
                                       pwdata[rmw_pkg::CTRL_WDOG_BIT];
    end
  end
  assign sleep_go = wr_done && hit_stat && pwdata[rmw_pkg::STAT_SLEEP_BIT] &&
                    ctrl_q[rmw_pkg::CTRL_UNLOCK_BIT];

  // ---------------------------------------------------------------------------
  // Watchdog.
  // ---------------------------------------------------------------------------
  logic tick_ok, wd_trip, key_ok, bus_err;
  // Stops when the RC is off while an external clock runs.
  assign tick_ok = tick_s && !tick_d1_q && !(ext_s && !rc_s);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_d1_q <= 1'b0;
    end else begin
      tick_d1_q <= tick_s;
    end
  end
  assign key_ok = wr_done && hit_wdog && key_armed_q && pwdata[7:0] == rmw_pkg::WDOG_KEY2;
  // Any other write to the watchdog register breaks the sequence.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_armed_q <= 1'b0;
    end else if (pwr_rst) begin
      key_armed_q <= 1'b0;
    end else if (wr_done && hit_wdog) begin
      key_armed_q <= pwdata[7:0] == rmw_pkg::WDOG_KEY1;
    end
  end
  assign wd_trip = wd_cnt_q == rmw_pkg::WDOG_TRIP;
  // Tick period must give at least 2 s from 0 to 8.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cnt_q <= 4'h0;
    end else if (pwr_rst || key_ok || rst_q.sys) begin
      wd_cnt_q <= 4'h0;
    end else if (tick_ok && !wd_trip && state_q == rmw_pkg::RMW_RUN) begin
      wd_cnt_q <= wd_cnt_q + 4'h1;
    end
  end

  // ---------------------------------------------------------------------------
  // Reset merging and cause flags.
  // ---------------------------------------------------------------------------
  logic wd_src, ba_src, combo_src, pin_warm;
  assign wd_src = wd_trip && ctrl_q[rmw_pkg::CTRL_WDOG_BIT];
  assign ba_src = (badaddr_s || (acc && unmapped)) &&
                  ctrl_q[rmw_pkg::CTRL_BADADDR_BIT];
  assign bus_err = ba_src;
  assign combo_src = combo_s;
  assign pin_warm = pin_s && !PIN_IS_COLD;
  assign warm_src = wd_src || bus_err || combo_src || pin_warm;
  // Outputs are registered; power-up dominates all.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_q <= '{pwr: 1'b1, sys: 1'b1, pcfg: 1'b1, dormant: 1'b1};
    end else begin
      rst_q.pwr <= pwr_rst;
      rst_q.sys <= pwr_rst || warm_src;
      rst_q.pcfg <= pwr_rst || (warm_src && ctrl_q[rmw_pkg::CTRL_PCFG_BIT]);
      rst_q.dormant <= pwr_rst || state_q == rmw_pkg::RMW_SLEEP || sleep_go;
    end
  end
  logic [7:0] set_v;
  assign set_v = {2'b00, bus_err, wd_src, combo_src, pin_s,
                  pin_s && state_q == rmw_pkg::RMW_SLEEP, 1'b0};
  // A new cause in the clearing cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= 8'h00;
    end else if (state_q == rmw_pkg::RMW_POR) begin
      flags_q <= 8'h00;
    end else if (wr_done && hit_stat) begin
      flags_q <= set_v;
    end else begin
      flags_q <= flags_q | set_v;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  pwr_feeds_a: assert property (rst_q.pwr |-> rst_q.sys && rst_q.pcfg && rst_q.dormant)
    else $error("power-up reset without wider resets");
  sys_cause_a: assert property (warm_src |=> rst_q.sys) else $error("no system reset");
  pcfg_gate_a: assert property (rst_q.pcfg |-> rst_q.sys) else $error("pcfg alone");
  sleep_hold_a: assert property (state_q == rmw_pkg::RMW_SLEEP |=> rst_q.dormant)
    else $error("dormant reset dropped");
  lock_a: assert property (!ctrl_q[rmw_pkg::CTRL_UNLOCK_BIT] |-> !sleep_go)
    else $error("sleep while locked");
  sleep_rd_a: assert property (pready |-> !prdata[rmw_pkg::STAT_SLEEP_BIT] || !hit_stat)
    else $error("sleep bit read one");
  wde_sticky_a: assert property ($fell(ctrl_q[rmw_pkg::CTRL_WDOG_BIT]) |-> $past(pwr_rst))
    else $error("watchdog enable cleared");
  wd_clear_a: assert property (key_ok && !pwr_rst |=> wd_cnt_q == 4'h0)
    else $error("key did not clear");
  wd_range_a: assert property (wd_cnt_q <= rmw_pkg::WDOG_TRIP) else $error("count past 8");
  flag_stick_a: assert property (flags_q[2] && !(wr_done && hit_stat)
    && state_q != rmw_pkg::RMW_POR |=> flags_q[2]) else $error("pin flag lost");

  // ---------------------------------------------------------------------------
  // Bus, sequencing, reset, watchdog and flag checks.
  // ---------------------------------------------------------------------------
  // The two phases of one register transfer, as the slave sees them.
  sequence apb_setup_s;
    psel && !penable;
  endsequence
  sequence apb_access_s;
    psel && penable && pready;
  endsequence

  // Every setup cycle is answered in the very next cycle; no wait states.
  apb_answer_a: assert property (apb_setup_s |=> apb_access_s or !penable)
    else $error("setup cycle not answered");

  // The answer stands for one cycle only, so a master never sees a stale ready.
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held for two cycles");

  // An unmapped address is flagged in the access cycle.
  err_unmapped_a: assert property (apb_setup_s && unmapped |=> pslverr)
    else $error("unmapped access without error");

  // Reads of an unmapped address return zeros.
  rd_unmapped_a: assert property (apb_setup_s && unmapped && !pwrite |=> prdata == 32'h0)
    else $error("unmapped read not zero");

  // The power-up request reaches its output one cycle later.
  pwr_follow_a: assert property (pwr_rst |=> rst_q.pwr)
    else $error("power-up reset missed");

  // Port reset follows a warm source only while its enable is set.
  pcfg_enable_a: assert property (warm_src && ctrl_q[rmw_pkg::CTRL_PCFG_BIT] |=> rst_q.pcfg)
    else $error("port reset missed");

  // Without the enable, port settings survive a warm reset.
  pcfg_keep_a: assert property (!pwr_rst && !(warm_src && ctrl_q[rmw_pkg::CTRL_PCFG_BIT])
    |=> !rst_q.pcfg) else $error("port reset without enable");

  // Sleep by itself never asserts system reset.
  sleep_only_a: assert property (state_q == rmw_pkg::RMW_SLEEP && !pwr_rst && !warm_src
    |=> !rst_q.sys) else $error("sleep asserted system reset");

  // An accepted sleep request moves the machine into sleep.
  sleep_enter_a: assert property (sleep_go && state_q == rmw_pkg::RMW_RUN
    |=> state_q == rmw_pkg::RMW_SLEEP) else $error("sleep not entered");

  // A watchdog timeout with the enable set causes system reset.
  wd_reset_a: assert property (wd_src |=> rst_q.sys)
    else $error("watchdog timeout ignored");

  // The counter only steps by one or returns to zero.
  wd_step_a: assert property ($changed(wd_cnt_q) |->
    wd_cnt_q == $past(wd_cnt_q) + 4'h1 || wd_cnt_q == 4'h0)
    else $error("watchdog count jumped");

  // With the RC off under an external clock the counter holds.
  wd_stop_a: assert property (ext_s && !rc_s && !pwr_rst && !key_ok && !rst_q.sys
    |=> $stable(wd_cnt_q)) else $error("watchdog ran without oscillator");

  // Any watchdog write other than the first key breaks an armed sequence.
  key_break_a: assert property (wr_done && hit_wdog && pwdata[7:0] != rmw_pkg::WDOG_KEY1
    |=> !key_armed_q) else $error("key sequence not broken");

  // A status write with no new cause leaves every flag clear.
  flag_clear_a: assert property (wr_done && hit_stat && set_v == 8'h00
    && state_q != rmw_pkg::RMW_POR |=> flags_q == 8'h00)
    else $error("status write did not clear");

  // Every active cause is latched in its own flag.
  flag_set_a: assert property (set_v != 8'h00 && state_q != rmw_pkg::RMW_POR
    |=> (flags_q & $past(set_v)) == $past(set_v))
    else $error("cause not latched");

  // A pin wake from sleep sets both pin flags.
  wake_flags_a: assert property (pin_s && state_q == rmw_pkg::RMW_SLEEP
    |=> flags_q[2] && flags_q[1]) else $error("pin wake flags missing");

  // The power-up state leaves every cause flag at zero.
  por_flags_a: assert property (state_q == rmw_pkg::RMW_POR |=> flags_q == 8'h00)
    else $error("flags survive power-up");

  // Power-up is held until the full count has run with the regulator up.
  por_hold_a: assert property (state_q == rmw_pkg::RMW_POR
    && !(rg_q[1] && por_cnt_q >= POR_COUNT - 1) |=> state_q == rmw_pkg::RMW_POR)
    else $error("power-up ended early");

  // Before the regulator is up the power-up count does not advance.
  por_wait_a: assert property (state_q == rmw_pkg::RMW_POR && !rg_q[1]
    |=> $stable(por_cnt_q)) else $error("count ran before regulator");
endmodule : rmw_top
`default_nettype wire

//--- tb/rmw_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module rmw_cpu_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ---------------------------------------------
  // Processor bus side
  // ---------------------------------------------
  // Idle bus at time zero.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end

  // One transfer; the request holds until pready is seen high at an edge or 20 edges have passed.
  // Released address and data are inverted so stale values never look valid.
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e, output logic to);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    to = (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : rmw_cpu_model
`default_nettype wire

//--- tb/reset_manager_watchdog_test.sv
`timescale 1ns/1ps
`default_nettype none
module reset_manager_watchdog_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, to;
  logic reg_rdy, pin, combo, wtick, rc_en, ext_ck, bareq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  rmw_pkg::rmw_rst_s rst_q;
  int mismatches, n_compared, n;

  rmw_top #(.POR_COUNT(16)) i_rmw_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .regulator_ready(reg_rdy), .reset_pin(pin),
    .port_combo_req(combo), .bad_address_req(bareq), .wdog_tick(wtick),
    .rc_osc_enable(rc_en), .ext_clk_in_use(ext_ck), .rst_q(rst_q));
  rmw_cpu_model i_rmw_cpu_model (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  // Free-running 250 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Verdict in one place, also reached when a wait runs out.
  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
    i_rmw_cpu_model.xfer(w, a, d, rd, er, to);
    if (to) begin
      mismatches++;
      tally_and_finish;
    end
  endtask : xf

  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    xf(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rd_chk

  // Power-up wait is bounded; the parameter keeps it short in simulation.
  task wait_pwr;
    n = 0;
    while (rst_q.pwr !== 1'b0 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 100) begin
      mismatches++;
      tally_and_finish;
    end
  endtask : wait_pwr

  // Low prescaler edges, slow enough for the synchroniser to see each one.
  task ticks(input int t);
    repeat (t) begin
      @(posedge pclk);
      wtick <= 1'b1;
      repeat (3) @(posedge pclk);
      wtick <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask : ticks

  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    presetn = 1'b0;
    {reg_rdy, pin, combo, wtick} = 4'h0;
    {rc_en, ext_ck, bareq} = 3'b100;
    mismatches = 0;
    n_compared = 0;
    void'($urandom(32'he3b25f26));
    repeat (3) @(posedge pclk);
    chk(rst_q, 32'hf);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (40) @(posedge pclk);
    chk(rst_q.pwr, 32'h1);
    reg_rdy <= 1'b1;
    wait_pwr();
    chk(rst_q, 32'h0);
    rd_chk(rmw_pkg::STAT_ADDR, 32'h0);
    xf(1'b0, 12'h00c + 12'(4 * ($urandom % 32)), 32'h0);
    chk({rd[30:0], er}, 32'h1);
    chk(rst_q.sys, 32'h0);
    xf(1'b1, rmw_pkg::CTRL_ADDR, 32'h70);
    rd_chk(rmw_pkg::CTRL_ADDR, 32'h70);
    xf(1'b1, rmw_pkg::CTRL_ADDR, 32'h0);
    rd_chk(rmw_pkg::CTRL_ADDR, 32'h10);
    n = 1 + $urandom % 6;
    ticks(n);
    rd_chk(rmw_pkg::WDOG_ADDR, 32'(n));
    xf(1'b1, rmw_pkg::WDOG_ADDR, 32'h05);
    xf(1'b1, rmw_pkg::WDOG_ADDR, 32'h0a);
    xf(1'b1, rmw_pkg::WDOG_ADDR, 32'h05);
    xf(1'b1, rmw_pkg::WDOG_ADDR, 32'h03);
    rd_chk(rmw_pkg::WDOG_ADDR, 32'(n));
    xf(1'b1, rmw_pkg::WDOG_ADDR, 32'h0a);
    xf(1'b1, rmw_pkg::WDOG_ADDR, 32'h03);
    rd_chk(rmw_pkg::WDOG_ADDR, 32'h0);
    ext_ck <= 1'b1;
    rc_en <= 1'b0;
    ticks(3);
    rd_chk(rmw_pkg::WDOG_ADDR, 32'h0);
    ext_ck <= 1'b0;
    rc_en <= 1'b1;
    ticks(7);
    rd_chk(rmw_pkg::WDOG_ADDR, 32'h7);
    chk(rst_q.sys, 32'h0);
    ticks(1);
    repeat (4) @(posedge pclk);
    rd_chk(rmw_pkg::STAT_ADDR, 32'h10);
    rd_chk(rmw_pkg::WDOG_ADDR, 32'h0);
    xf(1'b1, rmw_pkg::CTRL_ADDR, 32'h40);
    combo <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(rst_q, 32'h6);
    combo <= 1'b0;
    repeat (4) @(posedge pclk);
    xf(1'b1, rmw_pkg::CTRL_ADDR, 32'h20);
    combo <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(rst_q, 32'h4);
    combo <= 1'b0;
    xf(1'b0, 12'hffc, 32'h0);
    repeat (4) @(posedge pclk);
    rd_chk(rmw_pkg::STAT_ADDR, 32'h38);
    xf(1'b1, rmw_pkg::STAT_ADDR, 32'h80);
    repeat (2) @(posedge pclk);
    chk(rst_q, 32'h0);
    rd_chk(rmw_pkg::STAT_ADDR, 32'h0);
    bareq <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(rst_q, 32'h4);
    bareq <= 1'b0;
    repeat (4) @(posedge pclk);
    rd_chk(rmw_pkg::STAT_ADDR, 32'h20);
    xf(1'b1, rmw_pkg::STAT_ADDR, 32'h0);
    xf(1'b1, rmw_pkg::CTRL_ADDR, 32'h80);
    xf(1'b1, rmw_pkg::STAT_ADDR, 32'h80);
    repeat (2) @(posedge pclk);
    chk(rst_q, 32'h1);
    rd_chk(rmw_pkg::STAT_ADDR, 32'h0);
    pin <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(rst_q, 32'hf);
    pin <= 1'b0;
    wait_pwr();
    rd_chk(rmw_pkg::STAT_ADDR, 32'h06);
    rd_chk(rmw_pkg::CTRL_ADDR, 32'h0);
    tally_and_finish();
  end
endmodule : reset_manager_watchdog_test
`default_nettype wire
